// ===== dv/core_pipe_model.sv
// Core pipeline stand-in that issues SIMD work to the unit
`timescale 1ns/1ns
module core_pipe_model (
  input wire logic clk, // Core clock
  input wire logic rst_n, // Reset, active low
  input wire logic go, // Bench asks for one issue
  output logic simd_issue, // One-cycle issue
  output logic coproc1_usable_bit // Usable bit from status
);
  // Kernel sets the usable bit once out of reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      coproc1_usable_bit <= 1'b0;
      simd_issue <= 1'b0;
    end else begin
      coproc1_usable_bit <= 1'b1;
      simd_issue <= go;
    end
  end
endmodule

// ===== dv/simd_fp_ctrl_status_monitor.sv
// Checker on the ports of the SIMD control and status unit
`timescale 1ns/1ns
module simd_fp_ctrl_status_monitor (
  input wire logic clk, // Core clock
  input wire logic rst_n, // Reset, active low
  input wire logic cfg3_rd, // Config read
  input wire logic [31:0] cfg3_rdata, // Config data
  input wire logic coproc1_usable_bit, // Usable bit
  input wire logic simd_issue, // Issue
  input wire logic simd_accept, // Accept
  input wire logic csr_rd, // Status read
  input wire logic [31:0] csr_rdata, // Status data
  input wire logic csr_wr, // Status write
  input wire logic [31:0] csr_wdata, // Write data
  input wire logic op_valid, // Condition report
  input wire logic flush_to_zero, // Flush mode
  input wire logic non_trapping, // No-trap mode
  input wire logic snan_write, // NaN write
  input wire logic exc_valid, // Exception
  input wire logic [4:0] exception_code_field // Code
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_present_bit_set: assert property (cfg3_rd |=> cfg3_rdata == 32'h10000000)
    else $error("presence bit clear");
  a_reserved_zero: assert property (
    csr_rdata[31:25] == 7'h00 && !csr_rdata[23] && csr_rdata[20:19] == 2'h0)
    else $error("reserved status bits set");
  a_status_readback: assert property (
    (csr_wr && !op_valid) ##1 !csr_wr ##1 csr_rd
    |=> csr_rdata[31:18] == ($past(csr_wdata[31:18], 3) & 14'h0059))
    else $error("status readback wrong");
  a_flush_mirror: assert property (
    csr_wr ##1 !csr_wr |=> flush_to_zero == $past(csr_wdata[24], 2))
    else $error("flush mode wrong");
  a_nontrap_mirror: assert property (
    csr_wr ##1 !csr_wr |=> non_trapping == $past(csr_wdata[18], 2))
    else $error("no-trap mode wrong");
  a_accept_cause: assert property (
    simd_accept |-> $past(simd_issue) && $past(coproc1_usable_bit))
    else $error("accept without issue");
  a_disabled_cause: assert property (
    exc_valid && exception_code_field == 5'h15 |-> $past(simd_issue) && !simd_accept)
    else $error("disabled exception without issue");
  a_fp_exc_cause: assert property (
    exc_valid && exception_code_field == 5'h0e |-> $past(op_valid, 2))
    else $error("fp exception without report");
  a_code_legal: assert property (
    exc_valid |-> exception_code_field inside {5'h15, 5'h0e})
    else $error("bad exception code");
  a_snan_no_trap: assert property (snan_write |-> non_trapping && !exc_valid)
    else $error("nan write outside no-trap mode");
endmodule
bind simd_fp_ctrl_status_unit simd_fp_ctrl_status_monitor u_mon (.clk, .rst_n, .cfg3_rd,
  .cfg3_rdata, .coproc1_usable_bit, .simd_issue, .simd_accept, .csr_rd, .csr_rdata, .csr_wr,
  .csr_wdata, .op_valid, .flush_to_zero, .non_trapping, .snan_write, .exc_valid,
  .exception_code_field);

// ===== dv/simd_fp_ctrl_status_unit_tb.sv
// Self-checking bench for the SIMD control and status unit
`timescale 1ns/1ns
module simd_fp_ctrl_status_unit_tb;
  logic clk = 1'b0, rst_n = 1'b0, go = 1'b0, cfg3_rd = 1'b0, cfg5_wr = 1'b0, csr_rd = 1'b0;
  logic csr_wr = 1'b0, op_valid = 1'b0, simd_issue, coproc1_usable_bit, simd_accept;
  logic flush_to_zero, non_trapping, snan_write, exc_valid, acc, exc, snw;
  logic [31:0] cfg5_wdata = 32'h0, csr_wdata = 32'h0, cfg3_rdata, cfg5_rdata, csr_rdata, rd;
  logic [5:0] raw = 6'h00, default_sel, snan_code, sc, ds;
  logic [1:0] mode_in = 2'h0; // Subnormal input, comparison
  logic [4:0] exception_code_field, code;
  int error_cnt = 0, tests_run = 0;
  always #2 clk = ~clk;
  simd_fp_ctrl_status_unit u_dut (.clk, .rst_n, .cfg3_rd, .cfg3_rdata, .cfg5_wr, .cfg5_wdata,
    .cfg5_rdata, .coproc1_usable_bit, .simd_issue, .simd_accept, .csr_rd, .csr_rdata, .csr_wr,
    .csr_wdata, .op_valid, .raw_unimpl(raw[5]), .raw_invalid(raw[4]), .raw_divzero(raw[3]),
    .raw_overflow(raw[2]), .raw_tiny(raw[1]), .raw_inexact(raw[0]), .raw_sub_in(mode_in[1]),
    .is_compare(mode_in[0]), .round_mode(2'h0), .flush_to_zero, .non_trapping, .default_sel,
    .snan_code, .snan_write, .exc_valid, .exception_code_field);
  core_pipe_model u_core (.clk, .rst_n, .go, .simd_issue, .coproc1_usable_bit);
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic csr_w(logic [31:0] d);
    @(posedge clk) csr_wr <= 1'b1;
    csr_wdata <= d;
    @(posedge clk) csr_wr <= 1'b0;
  endtask
  task automatic csr_r();
    @(posedge clk) csr_rd <= 1'b1;
    @(posedge clk) csr_rd <= 1'b0;
    @(posedge clk) rd = csr_rdata;
  endtask
  // Collects every pulse seen in a short window
  task automatic watch();
    {acc, exc, snw, code, sc, ds} = '0;
    repeat (4) begin
      @(posedge clk) #1;
      if (simd_accept === 1'b1) acc = 1'b1;
      if (exc_valid === 1'b1) {exc, code} = {1'b1, exception_code_field};
      if (snan_write === 1'b1) {snw, sc} = {1'b1, snan_code};
      if (default_sel !== 6'h00) ds = default_sel;
    end
  endtask
  task automatic op(logic [5:0] v);
    @(posedge clk) op_valid <= 1'b1;
    raw <= v;
    @(posedge clk) op_valid <= 1'b0;
    raw <= 6'h00;
    watch();
  endtask
  task automatic issue();
    @(posedge clk) go <= 1'b1;
    @(posedge clk) go <= 1'b0;
    watch();
  endtask
  task automatic t_cfg();
    @(posedge clk) cfg3_rd <= 1'b1;
    @(posedge clk) cfg3_rd <= 1'b0;
    @(posedge clk) chk(cfg3_rdata, 32'h10000000);
    issue();
    chk(32'({acc, exc, code}), 32'h35);
    @(posedge clk) cfg5_wr <= 1'b1;
    cfg5_wdata <= 32'hffffffff;
    @(posedge clk) cfg5_wr <= 1'b0;
    repeat (2) @(posedge clk);
    chk(cfg5_rdata, 32'h08000000);
    issue();
    chk(32'({acc, exc}), 32'h2);
    $display("end of config test");
  endtask
  task automatic t_csr();
    csr_w(32'hffffffff);
    csr_r();
    chk(rd, 32'h0167ffff);
    chk(32'({flush_to_zero, non_trapping}), 32'h3);
    for (int i = 0; i < 4; i++) begin
      csr_w(32'(i));
      csr_r();
      chk(rd, 32'(i));
    end
    $display("end of register test");
  endtask
  task automatic t_flags();
    csr_w(32'h0);
    op(6'h02);
    csr_r();
    chk(32'({exc, rd[6:2]}), 32'h0);
    op(6'h08);
    chk(32'(ds), 32'h08);
    op(6'h04);
    chk(32'(ds), 32'h05);
    csr_r();
    chk(rd, 32'h00005034);
    chk(32'(exc), 32'h0);
    $display("end of flag test");
  endtask
  task automatic t_trap();
    csr_w(32'h00000f80);
    op(6'h10);
    chk(32'({exc, code}), 32'h2e);
    chk(32'(ds), 32'h00);
    csr_r();
    chk(rd, 32'h00010f80);
    csr_w(32'h0);
    op(6'h20);
    chk(32'({exc, code}), 32'h2e);
    csr_r();
    chk(rd, 32'h00020000);
    $display("end of trap test");
  endtask
  task automatic t_nx();
    csr_w(32'h00040800);
    op(6'h10);
    chk(32'({exc, snw, sc}), 32'h50);
    chk(32'(ds), 32'h00);
    csr_r();
    chk(rd, 32'h00040800);
    $display("end of no-trap test");
  endtask
  task automatic t_flush();
    csr_w(32'h01000000);
    mode_in <= 2'h2;
    op(6'h00);
    chk(32'(ds), 32'h01);
    @(posedge clk) mode_in <= 2'h3;
    op(6'h00);
    chk(32'(ds), 32'h00);
    @(posedge clk) mode_in <= 2'h0;
    op(6'h02);
    chk(32'(ds), 32'h03);
    csr_r();
    chk(rd, 32'h0100300c);
    $display("end of flush test");
  endtask
  // Mid-run reset must clear the register, the modes and the enable
  task automatic t_reset();
    csr_w(32'h01040f81);
    @(posedge clk) rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    chk(32'({flush_to_zero, non_trapping, cfg5_rdata[27]}), 32'h0);
    csr_r();
    chk(rd, 32'h0);
    issue();
    chk(32'({acc, exc, code}), 32'h35);
    $display("end of reset test");
  endtask
  task automatic final_report();
    $display("mismatches %0d comparisons %0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    t_cfg();
    t_csr();
    t_flags();
    t_trap();
    t_nx();
    t_flush();
    t_reset();
    final_report();
  end
  initial begin
    #8000;
    error_cnt++;
    final_report();
  end
endmodule

// ===== rtl/fp_cond_classify.sv
// Turns raw element conditions into the conditions that the status register records
`timescale 1ns/1ns
`include "simd_fp_params.svh"
module fp_cond_classify (
  input wire logic clk,                    // Core clock
  input wire logic rst_n,                  // Async reset, active low
  input wire logic op_valid,               // Operation result ready
  input wire logic raw_unimpl,             // Operation not implemented
  input wire logic raw_invalid,            // No usefully definable result
  input wire logic raw_divzero,            // Exact infinity from finite operands
  input wire logic raw_overflow,           // Rounded result beyond largest finite
  input wire logic raw_tiny,               // Tiny non-zero result
  input wire logic raw_inexact,            // Rounded result differs from exact
  input wire logic raw_sub_in,             // A subnormal input was seen
  input wire logic is_compare,             // Operation is a comparison
  input wire logic flush,                  // Flush-to-zero mode
  input wire logic underflow_en,           // Underflow enable
  fp_cond_if.src out                       // Classified conditions
);
  logic inexact_eff;
  logic underflow_eff;
  always_comb begin
    inexact_eff = raw_inexact | raw_overflow;
    underflow_eff = 1'b0;
    if (raw_tiny) begin
      if (flush) begin
        underflow_eff = 1'b1;
        inexact_eff = 1'b1;
      end else if (underflow_en) begin
        underflow_eff = 1'b1;
      end else begin
        underflow_eff = raw_inexact;
      end
    end
    if (flush && raw_sub_in && !is_compare) begin
      inexact_eff = 1'b1;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out.valid <= 1'b0;
      out.cond <= 6'h00;
    end else begin
      out.valid <= op_valid;
      out.cond <= {raw_unimpl, raw_invalid, raw_divzero, raw_overflow,
        underflow_eff, inexact_eff};
    end
  end
endmodule

// ===== rtl/fp_cond_if.sv
// Condition report carried from the result classifier to the register logic
`timescale 1ns/1ns
interface fp_cond_if;
  logic valid;
  simd_fp_pkg::cond_t cond;
  modport src (output valid, output cond);
  modport dst (input valid, input cond);
endinterface

// ===== rtl/simd_fp_ctrl_status_unit.sv
// Control and status logic for the SIMD floating-point unit
`timescale 1ns/1ns
`include "simd_fp_params.svh"
module simd_fp_ctrl_status_unit (
  input wire logic clk,                    // Core clock, 250 MHz
  input wire logic rst_n,                  // Async reset, active low
  input wire logic cfg3_rd,                // Read third config register
  output logic [31:0] cfg3_rdata,          // Third config register read data
  input wire logic cfg5_wr,                // Write fifth config register
  input wire logic [31:0] cfg5_wdata,      // Fifth config register write data
  output logic [31:0] cfg5_rdata,          // Fifth config register read data
  input wire logic coproc1_usable_bit,     // Coprocessor-1 usable from status register
  input wire logic simd_issue,             // SIMD instruction or vector access issued
  output logic simd_accept,                // Issued instruction may execute
  input wire logic csr_rd,                 // Copy-from-control request
  output logic [31:0] csr_rdata,           // Control/status read data
  input wire logic csr_wr,                 // Copy-to-control request
  input wire logic [31:0] csr_wdata,       // Control/status write data
  input wire logic op_valid,               // Element result with conditions ready
  input wire logic raw_unimpl,             // Unimplemented operation
  input wire logic raw_invalid,            // Invalid operation
  input wire logic raw_divzero,            // Divide by zero
  input wire logic raw_overflow,           // Overflow
  input wire logic raw_tiny,               // Tiny non-zero result
  input wire logic raw_inexact,            // Inexact
  input wire logic raw_sub_in,             // Subnormal input seen
  input wire logic is_compare,             // Operation is a comparison
  input wire logic [1:0] round_mode,       // Current rounding mode
  output logic flush_to_zero,              // Flush-to-zero mode in force
  output logic non_trapping,               // Non-trapping mode in force
  output logic [5:0] default_sel,          // Untrapped conditions that need default results
  output logic [5:0] snan_code,            // Low bits of signaling NaN for faulting element
  output logic snan_write,                 // Element gets signaling NaN
  output logic exc_valid,                  // Exception raised
  output logic [4:0] exception_code_field  // Exception code for cause register
);
  logic [31:0] csr;
  logic simd_enable_bit;
  logic [1:0] rm_q;
  fp_cond_if cond_bus ();
  simd_fp_pkg::cond_t enabled_mask;
  simd_fp_pkg::cond_t trap_hit;
  logic trap;
  logic [31:0] next_csr;

  // ------------------------------------------------------------
  // Condition classification
  // ------------------------------------------------------------
  fp_cond_classify classify (
    .clk(clk),
    .rst_n(rst_n),
    .op_valid(op_valid),
    .raw_unimpl(raw_unimpl),
    .raw_invalid(raw_invalid),
    .raw_divzero(raw_divzero),
    .raw_overflow(raw_overflow),
    .raw_tiny(raw_tiny),
    .raw_inexact(raw_inexact),
    .raw_sub_in(raw_sub_in),
    .is_compare(is_compare),
    .flush(csr[`CSR_FLUSH_BIT]),
    .underflow_en(csr[`CSR_ENABLE_LO + 1]),
    .out(cond_bus)
  );

  // Unimplemented is always enabled; no enable bit exists for it
  assign enabled_mask = {1'b1, csr[`CSR_ENABLE_HI:`CSR_ENABLE_LO]};
  assign trap_hit = cond_bus.cond & enabled_mask;
  assign trap = cond_bus.valid && (trap_hit != 6'h00);

  // ------------------------------------------------------------
  // Configuration bits
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      simd_enable_bit <= 1'b0;
    end else if (cfg5_wr) begin
      simd_enable_bit <= cfg5_wdata[`ENABLE_BIT];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg3_rdata <= 32'h00000000;
    end else if (cfg3_rd) begin
      cfg3_rdata <= 32'h00000000 | (32'h00000001 << `PRESENT_BIT);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg5_rdata <= 32'h00000000;
    end else begin
      cfg5_rdata <= {4'h0, simd_enable_bit, 27'h0000000};
    end
  end

  // ------------------------------------------------------------
  // Issue gating
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      simd_accept <= 1'b0;
    end else begin
      simd_accept <= simd_issue && simd_enable_bit && coproc1_usable_bit;
    end
  end

  // ------------------------------------------------------------
  // Control/status register, standalone from the scalar one
  // ------------------------------------------------------------
  always_comb begin
    next_csr = csr;
    if (csr_wr) begin
      next_csr = csr_wdata & `CSR_WRITE_MASK;
    end
    if (cond_bus.valid) begin
      if (!csr[`CSR_NONTRAP_BIT]) begin
        // Cause reflects the latest operation, set wins over a same-cycle write
        next_csr[`CSR_CAUSE_HI:`CSR_CAUSE_LO] = cond_bus.cond;
      end
      if (!trap) begin
        next_csr[`CSR_FLAG_HI:`CSR_FLAG_LO] = next_csr[`CSR_FLAG_HI:`CSR_FLAG_LO] |
          (cond_bus.cond[4:0] & ~csr[`CSR_ENABLE_HI:`CSR_ENABLE_LO]);
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      csr <= `CSR_RESET;
    end else begin
      csr <= next_csr;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      csr_rdata <= 32'h00000000;
    end else if (csr_rd) begin
      csr_rdata <= csr;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flush_to_zero <= 1'b0;
      non_trapping <= 1'b0;
      rm_q <= 2'h0;
    end else begin
      flush_to_zero <= next_csr[`CSR_FLUSH_BIT];
      non_trapping <= next_csr[`CSR_NONTRAP_BIT];
      rm_q <= next_csr[`CSR_RM_HI:`CSR_RM_LO];
    end
  end

  // ------------------------------------------------------------
  // Result selection and exceptions
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      default_sel <= 6'h00;
      snan_code <= 6'h00;
      snan_write <= 1'b0;
    end else begin
      // Untrapped conditions get quiet NaN, signed infinity or rounded value
      default_sel <= cond_bus.valid ? (cond_bus.cond & ~enabled_mask) : 6'h00;
      snan_write <= trap && csr[`CSR_NONTRAP_BIT];
      snan_code <= (trap && csr[`CSR_NONTRAP_BIT]) ? cond_bus.cond : 6'h00;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      exc_valid <= 1'b0;
      exception_code_field <= 5'h00;
    end else begin
      exc_valid <= 1'b0;
      exception_code_field <= 5'h00;
      if (simd_issue && !simd_enable_bit) begin
        exc_valid <= 1'b1;
        exception_code_field <= `EXC_SIMD_DISABLED;
      end else if (trap && !csr[`CSR_NONTRAP_BIT]) begin
        exc_valid <= 1'b1;
        exception_code_field <= `EXC_SIMD_FP;
      end
    end
  end

  // Rounding mode is tracked from the register in rm_q but not exported; the round_mode port is unused
  logic unused_rm;
  assign unused_rm = ^{round_mode, rm_q};
endmodule

// ===== rtl/simd_fp_params.svh
// Constants for the SIMD floating-point control and status unit
`ifndef SIMD_FP_PARAMS_SVH
`define SIMD_FP_PARAMS_SVH
`define PRESENT_BIT 28
`define ENABLE_BIT 27
`define CSR_FLUSH_BIT 24
`define CSR_IMPL_HI 22
`define CSR_IMPL_LO 21
`define CSR_NONTRAP_BIT 18
`define CSR_CAUSE_HI 17
`define CSR_CAUSE_LO 12
`define CSR_ENABLE_HI 11
`define CSR_ENABLE_LO 7
`define CSR_FLAG_HI 6
`define CSR_FLAG_LO 2
`define CSR_RM_HI 1
`define CSR_RM_LO 0
`define CSR_WRITE_MASK 32'h0167ffff
`define CSR_RESET 32'h00000000
`define EXC_SIMD_DISABLED 5'h15
`define EXC_SIMD_FP 5'h0e
`define SNAN_COND_BITS 6
`endif

// ===== rtl/simd_fp_pkg.sv
// Types for the SIMD floating-point control and status unit
package simd_fp_pkg;
  typedef enum logic [1:0] {
    rm_nearest,
    rm_zero,
    rm_plus_inf,
    rm_minus_inf
  } round_mode_e;
  // Condition vector order: {unimpl, invalid, divzero, overflow, underflow, inexact}
  typedef logic [5:0] cond_t;
  typedef enum logic [1:0] {
    st_idle,
    st_commit
  } commit_state_e;
endpackage
